/* verilog/rscl_pkg.sv */
// Purpose: shared constants and carrier types for the strap configuration latch
// Assumes: mclk at 200 MHz; register bus is 32-bit Avalon-MM, byte addressed
// Notes:   the reset pin is a plain synchronous input, not a reset of this logic
package rscl_pkg;

	// clock and reset pulse timing
	localparam int CLK_PERIOD_PS      = 5000;
	localparam int FULL_RESET_MIN_NS  = 1200;
	localparam int PARTIAL_MIN_NS     = 40;
	// least times round up to whole cycles
	localparam int FULL_RESET_CYCLES  = (FULL_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PARTIAL_MIN_CYCLES = (PARTIAL_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LOW_COUNT_W        = 9;

	// register offsets (byte addresses)
	localparam logic [3:0] CONFIG_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;

	// config register fields
	localparam int CFG_OS_LSB    = 0;
	localparam int CFG_CRC_BIT   = 4;
	localparam int CFG_BURST_BIT = 5;
	localparam int CFG_SEQ_BIT   = 6;
	localparam int CFG_RANGE_LSB = 8;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] CONFIG_MASK  = 32'h0000_0377;

	// status register fields
	localparam int STS_SW_MODE_BIT  = 0;
	localparam int STS_INT_REF_BIT  = 1;
	localparam int STS_SERIAL_BIT   = 2;
	localparam int STS_ONE_LINE_BIT = 3;
	localparam int STS_RANGE_LSB    = 4;
	localparam int STS_VALID_BIT    = 8;

	// avalon response codes
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLAVEERROR  = 2'h2;
	localparam logic [1:0] RESP_DECODEERROR = 2'h3;

	// range/mode select value that means register-controlled operation
	localparam logic [1:0] RANGE_SEL_SW_MODE = 2'h0;

	typedef struct packed {
		logic [1:0] rangeModeSelectPins;
		logic       referenceSourceSelect;
		logic       serialParallelSelect;
		logic       serialOneLineSelect;
		logic       checkCodeEnablePin;
		logic       burstEnablePin;
		logic       sequencerEnablePin;
		logic [2:0] oversamplingRatioPins;
	} rscl_strap_s;

	typedef struct packed {
		logic       swMode;
		logic       intRefEnable;
		logic       serialIf;
		logic       oneLine;
		logic       checkCodeEn;
		logic       burst_enable_pin;
		logic       sequencer_enable_pin;
		logic [2:0] osRatio;
	} rscl_cfg_s;

	typedef struct packed {
		logic       perChannelCfg;
		logic       fullSequencer;
		logic       diagConversions;
		logic       oversampling;
		logic       checkCode;
		logic       lineModes;
		logic       registerAccess;
	} rscl_avail_s;

	localparam rscl_cfg_s CFG_DEFAULT = '0;

endpackage

/* verilog/rscl_pulse_meter.sv */
// Purpose: measures each low pulse on the reset pin and classifies its release
// Assumes: resetPinN is synchronous to mclk
// Notes:   pulses shorter than the partial minimum are treated as glitches
`timescale 1ns/1ps
`default_nettype none

module rscl_pulse_meter
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic resetPinN,
	output var  logic fullRelease,
	output var  logic partialRelease
);

	logic                             pinPrev_q;
	logic [rscl_pkg::LOW_COUNT_W-1:0] lowCount_q;
	logic                             rising;

	assign rising = resetPinN & ~pinPrev_q;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pinPrev_q <= 1'b1;
		else
			pinPrev_q <= resetPinN;
	end

	// saturate once the full reset length is reached
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			lowCount_q <= '0;
		else if (resetPinN)
			lowCount_q <= '0;
		else if (lowCount_q < rscl_pkg::LOW_COUNT_W'(rscl_pkg::FULL_RESET_CYCLES))
			lowCount_q <= lowCount_q + 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			fullRelease    <= 1'b0;
			partialRelease <= 1'b0;
		end
		else
		begin
			fullRelease    <= rising &&
				lowCount_q >= rscl_pkg::LOW_COUNT_W'(rscl_pkg::FULL_RESET_CYCLES);
			partialRelease <= rising &&
				lowCount_q >= rscl_pkg::LOW_COUNT_W'(rscl_pkg::PARTIAL_MIN_CYCLES) &&
				lowCount_q <  rscl_pkg::LOW_COUNT_W'(rscl_pkg::FULL_RESET_CYCLES);
		end
	end

endmodule

`default_nettype wire

/* verilog/rscl_config_latch.sv */
// Purpose: latches strap configuration at full reset release, gates register access
// Assumes: strap and reset pins synchronous to mclk; Avalon-MM slave with waitrequest
// Notes:   rst_n clears this logic; the reset pin is the device's own reset input
//
// What this block does
// - mode chosen only at full-reset release, then held
// - range/mode pins both low selects register control
// - nonzero range/mode pins: pin control plus range
// - register control ignores later range/mode pin changes
// - mode changes only through another full reset
// - pin control: settings come from pins only
// - pin control refuses all register reads, writes
// - register control: interface, reference still from straps
// - reference pin high enables internal reference
// - reference choice ignored until next full reset
// - serial/parallel pin low parallel, high serial
// - serial: one-line pin picks one or two lines
// - interface pins ignored after latching
// - full functions in register control, restricted otherwise
// - pin control latches burst, sequencer; check, oversampling in serial only
// - partial reset keeps latched straps and registers
`timescale 1ns/1ps
`default_nettype none

module rscl_config_latch
(
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire logic                  resetPinN,
	input  wire rscl_pkg::rscl_strap_s strapPins,
	input  wire logic [3:0]            avsAddress,
	input  wire logic                  avsRead,
	input  wire logic                  avsWrite,
	input  wire logic [31:0]           avsWriteData,
	input  wire logic [3:0]            avsByteEnable,
	output var  logic [31:0]           avsReadData,
	output var  logic [1:0]            avsResponse,
	output var  logic                  avsWaitRequest,
	output var  rscl_pkg::rscl_cfg_s   activeCfg,
	output var  rscl_pkg::rscl_avail_s available,
	output var  logic [1:0]            analogRange,
	output var  logic                  configValid,
	output var  logic                  partialResetPulse
);

	typedef enum logic [1:0] {
		ST_UNCONFIGURED,
		ST_PIN_CONTROL,
		ST_REG_CONTROL
	} rscl_mode_e;

	rscl_mode_e            mode_q;
	rscl_mode_e            mode_d;
	rscl_pkg::rscl_strap_s strapDly_q;
	rscl_pkg::rscl_cfg_s   latched_q;
	rscl_pkg::rscl_cfg_s   latched_d;
	logic [31:0]           config_q;
	logic [31:0]           configMerged;
	logic [31:0]           status;
	logic                  fullRelease;
	logic                  partialRelease;
	logic                  accessAllowed;
	logic                  hitConfig;
	logic                  hitStatus;
	logic                  busTaken;

	rscl_pulse_meter u_meter
	(
		.mclk           (mclk),
		.rst_n          (rst_n),
		.resetPinN      (resetPinN),
		.fullRelease    (fullRelease),
		.partialRelease (partialRelease)
	);

	// meter pulse lags the release by one cycle, so straps are delayed to match
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			strapDly_q <= '0;
		else
			strapDly_q <= strapPins;
	end

	always_comb
	begin
		mode_d    = mode_q;
		latched_d = latched_q;
		if (fullRelease)
		begin
			if (strapDly_q.rangeModeSelectPins == rscl_pkg::RANGE_SEL_SW_MODE)
				mode_d = ST_REG_CONTROL;
			else
				mode_d = ST_PIN_CONTROL;
			latched_d              = rscl_pkg::CFG_DEFAULT;
			latched_d.swMode       = (mode_d == ST_REG_CONTROL);
			latched_d.intRefEnable = strapDly_q.referenceSourceSelect;
			latched_d.serialIf     = strapDly_q.serialParallelSelect;
			latched_d.oneLine      = strapDly_q.serialParallelSelect &
			                         strapDly_q.serialOneLineSelect;
			if (mode_d == ST_PIN_CONTROL)
			begin
				latched_d.burst_enable_pin = strapDly_q.burstEnablePin;
				latched_d.sequencer_enable_pin   = strapDly_q.sequencerEnablePin;
				// pin-controlled parallel has neither feature
				if (strapDly_q.serialParallelSelect)
				begin
					latched_d.checkCodeEn = strapDly_q.checkCodeEnablePin;
					latched_d.osRatio     = strapDly_q.oversamplingRatioPins;
				end
			end
		end
	end

	// no other path alters the mode or the latched straps; partial release is ignored
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			mode_q    <= ST_UNCONFIGURED;
			latched_q <= rscl_pkg::CFG_DEFAULT;
		end
		else
		begin
			mode_q    <= mode_d;
			latched_q <= latched_d;
		end
	end

	assign accessAllowed = (mode_q == ST_REG_CONTROL);
	assign hitConfig     = (avsAddress == rscl_pkg::CONFIG_OFFSET);
	assign hitStatus     = (avsAddress == rscl_pkg::STATUS_OFFSET);
	assign busTaken      = (avsRead | avsWrite) & ~avsWaitRequest;

	generate
		for (genvar b = 0; b < 4; b++)
		begin : g_lane
			assign configMerged[b*8 +: 8] = avsByteEnable[b] ?
				avsWriteData[b*8 +: 8] : config_q[b*8 +: 8];
		end
	endgenerate

	// full release returns registers to defaults; a partial one leaves them
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			config_q <= rscl_pkg::CONFIG_RESET;
		else if (fullRelease)
			config_q <= rscl_pkg::CONFIG_RESET;
		else if (busTaken && avsWrite && hitConfig && accessAllowed)
			config_q <= configMerged & rscl_pkg::CONFIG_MASK;
	end

	always_comb
	begin
		status = '0;
		status[rscl_pkg::STS_SW_MODE_BIT]  = latched_q.swMode;
		status[rscl_pkg::STS_INT_REF_BIT]  = latched_q.intRefEnable;
		status[rscl_pkg::STS_SERIAL_BIT]   = latched_q.serialIf;
		status[rscl_pkg::STS_ONE_LINE_BIT] = latched_q.oneLine;
		status[rscl_pkg::STS_RANGE_LSB +: 2] = analogRange;
		status[rscl_pkg::STS_VALID_BIT]    = configValid;
	end

	// one wait cycle per access: waitrequest drops for exactly one cycle
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			avsWaitRequest <= 1'b1;
		else if ((avsRead | avsWrite) && avsWaitRequest)
			avsWaitRequest <= 1'b0;
		else
			avsWaitRequest <= 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			avsReadData <= '0;
			avsResponse <= rscl_pkg::RESP_OKAY;
		end
		else if ((avsRead | avsWrite) && avsWaitRequest)
		begin
			avsReadData <= '0;
			if (!hitConfig && !hitStatus)
				avsResponse <= rscl_pkg::RESP_DECODEERROR;
			else if (!accessAllowed)
				avsResponse <= rscl_pkg::RESP_SLAVEERROR;
			else
			begin
				avsResponse <= rscl_pkg::RESP_OKAY;
				if (avsRead)
					avsReadData <= hitConfig ? config_q : status;
			end
		end
	end

	// effective settings: pins in pin control; in register control, register fields plus strapped interface and reference
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			activeCfg   <= rscl_pkg::CFG_DEFAULT;
			analogRange <= '0;
		end
		else if (mode_q == ST_REG_CONTROL)
		begin
			activeCfg             <= latched_q;
			activeCfg.osRatio     <= config_q[rscl_pkg::CFG_OS_LSB +: 3];
			activeCfg.checkCodeEn <= config_q[rscl_pkg::CFG_CRC_BIT];
			activeCfg.burst_enable_pin     <= config_q[rscl_pkg::CFG_BURST_BIT];
			activeCfg.sequencer_enable_pin       <= config_q[rscl_pkg::CFG_SEQ_BIT];
			analogRange           <= config_q[rscl_pkg::CFG_RANGE_LSB +: 2];
		end
		else
		begin
			activeCfg   <= latched_q;
			// range pins stay live in pin control; mode is not re-read from them
			analogRange <= (mode_q == ST_PIN_CONTROL) ? strapPins.rangeModeSelectPins : 2'h0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			available <= '0;
		else
		begin
			available.perChannelCfg   <= (mode_q == ST_REG_CONTROL);
			available.fullSequencer   <= (mode_q == ST_REG_CONTROL);
			available.diagConversions <= (mode_q == ST_REG_CONTROL);
			available.registerAccess  <= accessAllowed;
			available.oversampling    <= (mode_q == ST_REG_CONTROL) ||
			                             (mode_q == ST_PIN_CONTROL && latched_q.serialIf);
			available.checkCode       <= (mode_q == ST_REG_CONTROL) ||
			                             (mode_q == ST_PIN_CONTROL && latched_q.serialIf);
			available.lineModes       <= (mode_q != ST_UNCONFIGURED) && latched_q.serialIf;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			configValid       <= 1'b0;
			partialResetPulse <= 1'b0;
		end
		else
		begin
			configValid       <= (mode_q != ST_UNCONFIGURED);
			partialResetPulse <= partialRelease;
		end
	end

endmodule

`default_nettype wire

/* sim/rscl_checker_properties.sv */
// Purpose: concurrent checks on the strap latch ports
// Assumes: one clock domain; rst_n synchronous, active low
// Notes:   a full release edge is where resetPinN is first seen high
`timescale 1ns/1ps
`default_nettype none
module rscl_checker_properties
(
	input wire logic                  mclk,
	input wire logic                  rst_n,
	input wire logic                  resetPinN,
	input wire rscl_pkg::rscl_strap_s strapPins,
	input wire logic                  avsRead,
	input wire logic                  avsWrite,
	input wire logic [31:0]           avsReadData,
	input wire logic [1:0]            avsResponse,
	input wire logic                  avsWaitRequest,
	input wire rscl_pkg::rscl_cfg_s   activeCfg,
	input wire rscl_pkg::rscl_avail_s available,
	input wire logic [1:0]            analogRange,
	input wire logic                  configValid,
	input wire logic                  partialResetPulse
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// latched outputs move three edges after the release edge
	sequence fullEdge3;
		$past(resetPinN, 3) && !$past(resetPinN, 4);
	endsequence
	chk_wait_answer: assert property ((avsRead || avsWrite) && avsWaitRequest
		|=> !avsWaitRequest ##1 avsWaitRequest) else $error("access not answered in one wait");
	chk_pin_refused: assert property (!avsWaitRequest && !activeCfg.swMode
		|-> avsResponse != rscl_pkg::RESP_OKAY && avsReadData == 32'h0000_0000)
		else $error("register access accepted without register control");
	chk_mode_held: assert property ($changed(activeCfg.swMode) |-> fullEdge3)
		else $error("mode changed without full release");
	chk_straps_held: assert property (
		$changed({activeCfg.intRefEnable, activeCfg.serialIf, activeCfg.oneLine}) |-> fullEdge3)
		else $error("reference or interface changed without full release");
	chk_valid_rise: assert property ($rose(configValid) |-> fullEdge3)
		else $error("config valid rose without full release");
	chk_parallel_limits: assert property (
		configValid && !activeCfg.swMode && !activeCfg.serialIf |-> activeCfg.osRatio == 3'h0
		&& !activeCfg.checkCodeEn && !available.oversampling && !available.checkCode)
		else $error("pin parallel offers oversampling or check code");
	chk_avail_mode: assert property (configValid |-> available.registerAccess == activeCfg.swMode
		&& available.diagConversions == activeCfg.swMode && available.lineModes == activeCfg.serialIf)
		else $error("function set does not follow mode");
	chk_range_live: assert property (
		configValid && !activeCfg.swMode && $past(configValid) && !$past(activeCfg.swMode)
		|-> analogRange == $past(strapPins.rangeModeSelectPins)) else $error("range not from pins");
	chk_partial_keeps: assert property (
		partialResetPulse |-> $stable(activeCfg) && $stable(configValid))
		else $error("partial reset disturbed latched config");
	cover property (configValid && activeCfg.swMode);
	cover property (configValid && activeCfg.serialIf && !activeCfg.swMode);
	cover property (partialResetPulse);
endmodule
`default_nettype wire

/* sim/rscl_host_model.sv */
// Purpose: host side model driving the reset pin and strap levels
// Assumes: every change lands by non-blocking assignment after mclk rises
// Notes:   straps are set at the release edge and held, so they latch cleanly
`timescale 1ns/1ps
`default_nettype none
module rscl_host_model
(
	input  wire logic                  mclk,
	output var  logic                  resetPinN,
	output var  rscl_pkg::rscl_strap_s strapPins
);
	initial resetPinN = 1'b1;
	initial strapPins = '0;
	// low for n sampled cycles; 240 or more is a full reset
	task automatic pulse(input int n, input rscl_pkg::rscl_strap_s s);
		@(posedge mclk);
		resetPinN <= 1'b0;
		repeat (n) @(posedge mclk);
		resetPinN <= 1'b1;
		strapPins <= s;
		repeat (6) @(posedge mclk);
	endtask
	task automatic setStraps(input rscl_pkg::rscl_strap_s s);
		@(posedge mclk);
		strapPins <= s;
	endtask
endmodule
`default_nettype wire

/* sim/test_reset_strap_config_latch.sv */
// Purpose: directed bench for the strap configuration latch
// Assumes: host model owns reset pin and straps
// Notes:   each scenario task judges its own results
`timescale 1ns/1ps
`default_nettype none
module test_reset_strap_config_latch;
	logic                  mclk = 1'b0;
	logic                  rst_n = 1'b0;
	logic [3:0]            avsAddress = 4'h0;
	logic                  avsRead = 1'b0;
	logic                  avsWrite = 1'b0;
	logic [31:0]           avsWriteData = 32'h0000_0000;
	logic [3:0]            avsByteEnable = 4'hF;
	logic [31:0]           avsReadData, rd;
	logic [1:0]            avsResponse, rs, analogRange;
	logic                  avsWaitRequest, configValid, partialResetPulse, resetPinN;
	rscl_pkg::rscl_strap_s strapPins;
	rscl_pkg::rscl_cfg_s   activeCfg;
	rscl_pkg::rscl_avail_s available;
	int                    errors = 0, nChecks = 0, nPartial = 0;
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) if (partialResetPulse === 1'b1) nPartial++;
	rscl_host_model i_host (.mclk, .resetPinN, .strapPins);
	rscl_config_latch i_dut (.mclk, .rst_n, .resetPinN, .strapPins, .avsAddress, .avsRead,
		.avsWrite, .avsWriteData, .avsByteEnable, .avsReadData, .avsResponse, .avsWaitRequest,
		.activeCfg, .available, .analogRange, .configValid, .partialResetPulse);
	task automatic end_sim();
		if (errors == 0 && nChecks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		nChecks++;
		if (s !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		input logic [3:0] be);
		int t;
		t = 0;
		@(posedge mclk);
		avsAddress <= a;
		avsWriteData <= wd;
		avsByteEnable <= be;
		avsWrite <= wr;
		avsRead <= !wr;
		// look between edges so the value seen is the one the next edge samples
		@(negedge mclk);
		while (avsWaitRequest !== 1'b0 && t < 20)
		begin
			@(negedge mclk);
			t++;
		end
		rd = avsReadData;
		rs = avsResponse;
		@(posedge mclk);
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		chk("waitrequest", 32'(t < 20), 32'h0000_0001);
	endtask
	// c is the config register, live the range pins now applied
	task automatic chkState(input rscl_pkg::rscl_strap_s p, input logic [31:0] c,
		input logic [1:0] live);
		rscl_pkg::rscl_cfg_s e;
		logic sw, sr;
		sw = p.rangeModeSelectPins === rscl_pkg::RANGE_SEL_SW_MODE;
		sr = p.serialParallelSelect;
		e = {sw, p.referenceSourceSelect, sr, sr & p.serialOneLineSelect,
			sw ? c[6:4] : {sr & p.checkCodeEnablePin, p.burstEnablePin, p.sequencerEnablePin},
			sw ? c[2:0] : (sr ? p.oversamplingRatioPins : 3'h0)};
		chk("activeCfg", 32'(activeCfg), 32'(e));
		chk("available", 32'(available), 32'({sw, sw, sw, sw | sr, sw | sr, sr, sw}));
		chk("analogRange", 32'(analogRange), 32'(sw ? c[9:8] : live));
		chk("configValid", 32'(configValid), 32'h0000_0001);
	endtask
	task automatic tUnconfigured();
		bus(1'b0, rscl_pkg::STATUS_OFFSET, 32'h0000_0000, 4'hF);
		chk("unconf resp", 32'(rs), 32'(rscl_pkg::RESP_SLAVEERROR));
		chk("unconf data", rd, 32'h0000_0000);
	endtask
	task automatic tSoftware();
		i_host.pulse(240, 11'h17F);
		chkState(11'h17F, 32'h0000_0000, 2'h0);
		bus(1'b1, rscl_pkg::CONFIG_OFFSET, 32'hFFFF_FFFF, 4'hF);
		bus(1'b0, rscl_pkg::CONFIG_OFFSET, 32'h0000_0000, 4'hF);
		chk("config", rd, 32'h0000_0377);
		chkState(11'h17F, 32'h0000_0377, 2'h0);
		bus(1'b0, rscl_pkg::STATUS_OFFSET, 32'h0000_0000, 4'hF);
		chk("status", rd, 32'h0000_0133);
		bus(1'b1, rscl_pkg::CONFIG_OFFSET, 32'h0000_0000, 4'h1);
		bus(1'b0, rscl_pkg::CONFIG_OFFSET, 32'h0000_0000, 4'hF);
		chk("config lanes", rd, 32'h0000_0300);
		bus(1'b1, 4'h8, 32'hFFFF_FFFF, 4'hF);
		chk("unmapped resp", 32'(rs), 32'(rscl_pkg::RESP_DECODEERROR));
		// change every strap but the reference select: nothing may follow in register control
		i_host.setStraps(11'h382);
		repeat (3) @(posedge mclk);
		chkState(11'h17F, 32'h0000_0300, 2'h0);
	endtask
	task automatic tPartial();
		i_host.pulse(20, 11'h382);
		chk("partial pulses", 32'(nPartial), 32'h0000_0001);
		chkState(11'h17F, 32'h0000_0300, 2'h0);
		bus(1'b0, rscl_pkg::CONFIG_OFFSET, 32'h0000_0000, 4'hF);
		chk("config kept", rd, 32'h0000_0300);
	endtask
	task automatic tPinParallel();
		i_host.pulse(240, 11'h47D);
		chkState(11'h47D, 32'h0000_0000, 2'h2);
		bus(1'b1, rscl_pkg::CONFIG_OFFSET, 32'hFFFF_FFFF, 4'hF);
		chk("pin write resp", 32'(rs), 32'(rscl_pkg::RESP_SLAVEERROR));
		bus(1'b0, rscl_pkg::CONFIG_OFFSET, 32'h0000_0000, 4'hF);
		chk("pin read resp", 32'(rs), 32'(rscl_pkg::RESP_SLAVEERROR));
		chk("pin read data", rd, 32'h0000_0000);
		i_host.setStraps(11'h382);
		repeat (3) @(posedge mclk);
		chkState(11'h47D, 32'h0000_0000, 2'h1);
	endtask
	task automatic tPinSerial(input rscl_pkg::rscl_strap_s p);
		i_host.pulse(240, p);
		chkState(p, 32'h0000_0000, p.rangeModeSelectPins);
	endtask
	initial
	begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		tUnconfigured();
		tSoftware();
		tPartial();
		tPinParallel();
		tPinSerial(11'h7EB);
		tPinSerial(11'h7AB);
		end_sim();
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		errors++;
		end_sim();
	end
endmodule
bind rscl_config_latch rscl_checker_properties i_chk (.mclk, .rst_n, .resetPinN, .strapPins,
	.avsRead, .avsWrite, .avsReadData, .avsResponse, .avsWaitRequest, .activeCfg, .available,
	.analogRange, .configValid, .partialResetPulse);
`default_nettype wire
